// file: rtl/servo_sel_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SERVO_SEL_REGS_SVH
`define SERVO_SEL_REGS_SVH
`define OFS_CTRL        8'h00
`define OFS_TL_FIRST    8'h04
`define OFS_TL_SECOND   8'h08
`define OFS_SLOPE_FIRST 8'h0c
`define OFS_SLOPE_SECND 8'h10
`define OFS_INER_FIRST  8'h14
`define OFS_INER_SECND  8'h18
`define OFS_STATE       8'h1c
`define OFS_SPEED_OUT   8'h20
`define OFS_INT_STATUS  8'h24
`define OFS_INT_MASK    8'h28
`define OFS_SPEED_BASE  8'h40
`define OFS_SPEED_LAST  8'h5c
`define CTRL_TLSEL_LSB  0
`define CTRL_SRC_LSB    4
`define CTRL_ZCLAMP_BIT 8
`define CTRL_TORQUE_BIT 12
`define CTRL_RESET      32'h0000_0011
`define TL_RESET        16'h0bb8
`define INER_RESET      16'h0064
`define INT_ALARM_BIT   0
`define INT_RAMP_BIT    1
`define TLSEL_RAMPED    3'h3
`define TLSEL_SPLIT     3'h2
`define SRC_FOUR        2'h1
`define SRC_ANALOG      2'h2
`define SRC_EIGHT       2'h3
`define CLK_PERIOD_NS   40
`define RAMP_TICK_NS    1000
`define RAMP_TICK_CYC   ((`RAMP_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: rtl/servo_sel_pkg.sv
// Types shared by the input selection logic
package servo_sel_pkg;
    typedef logic [15:0] limit_t;
    typedef enum logic [1:0] {
        RAMP_HOLD = 2'b01,
        RAMP_SLEW = 2'b10
    } ramp_state_t;
endpackage

// file: rtl/speed_rd_if.sv
// Carrier between the selector logic and the speed table
`timescale 1ns/1ps
interface speed_rd_if #(parameter int DW = 16);
    logic [2:0]    sel_addr;
    logic [DW-1:0] sel_data;
    logic [2:0]    bus_addr;
    logic [DW-1:0] bus_data;
    logic          wr_en;
    logic [DW-1:0] wr_data;
    modport ctrl (output sel_addr, bus_addr, wr_en, wr_data, input sel_data, bus_data);
    modport mem  (input sel_addr, bus_addr, wr_en, wr_data, output sel_data, bus_data);
endinterface

// file: rtl/input_sync.sv
// Three-stage synchroniser with agreement filter per input bit
`timescale 1ns/1ps
module input_sync #(
    parameter int W = 9
) (
    input  wire logic         clk,      // Block clock
    input  wire logic         rst_n,    // Async reset, low
    input  wire logic [W-1:0] async_in, // Raw pins
    output logic      [W-1:0] stable_d, // Next filtered value
    output logic      [W-1:0] stable_q  // Filtered value
);
    initial if (W < 1) $error("input_sync width must be positive");

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            // First stage feeds only the second
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                end else begin
                    s1_q <= async_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end
            // Change counts only once stages two and three agree
            assign stable_d[i] = (s2_q == s3_q) ? s3_q : stable_q[i];
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    stable_q[i] <= 1'b0;
                end else begin
                    stable_q[i] <= stable_d[i];
                end
            end
        end
    endgenerate
endmodule // input_sync

// file: rtl/speed_mem.sv
// Eight-entry internal speed table, two registered read ports
`timescale 1ns/1ps
module speed_mem #(
    parameter int DW = 16
) (
    input wire logic clk,  // Block clock
    speed_rd_if.mem  port  // Read and write port group
);
    initial if (DW < 2) $error("speed_mem width too small");

    logic [DW-1:0] mem_q [8];

    // Bus writes; no reset so the table infers as plain storage
    always_ff @(posedge clk) begin
        if (port.wr_en) begin
            mem_q[port.bus_addr] <= port.wr_data;
        end
    end

    // Registered reads keep access times fixed
    always_ff @(posedge clk) begin
        port.sel_data <= mem_q[port.sel_addr];
        port.bus_data <= mem_q[port.bus_addr];
    end
endmodule // speed_mem

// file: rtl/servo_input_selection_logic.sv
// Servo input-function selection: torque limit ramp, speed select, APB registers
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "servo_sel_regs.svh"
module servo_input_selection_logic #(
    parameter int LW = 16,                 // Limit and ratio width
    parameter int SW = 16,                 // Speed word width
    parameter int TICK_CYC = `RAMP_TICK_CYC // Cycles per ramp step
) (
    input  wire logic          pclk,                   // Clock, 25 MHz
    input  wire logic          presetn,                // Async reset, low
    input  wire logic          psel,                   // APB select
    input  wire logic          penable,                // APB enable
    input  wire logic          pwrite,                 // APB direction
    input  wire logic [7:0]    paddr,                  // APB byte address
    input  wire logic [31:0]   pwdata,                 // APB write data
    output logic      [31:0]   prdata,                 // APB read data
    output logic               pready,                 // APB ready
    output logic               pslverr,                // APB error
    input  wire logic          torque_limit_select_in, // Second limit select
    input  wire logic          speed_sel_bit0,         // Speed selector 1
    input  wire logic          speed_sel_bit1,         // Speed selector 2
    input  wire logic          speed_sel_bit2,         // Speed selector 3
    input  wire logic          zero_clamp_in,          // Zero speed clamp
    input  wire logic          speed_sign_in,          // Speed sign
    input  wire logic          torque_sign_in,         // Torque direction
    input  wire logic          forced_alarm_in,        // Forced alarm
    input  wire logic          inertia_switch_in,      // Second inertia
    input  wire logic [SW-1:0] analog_speed_in,        // Digitised analog speed
    output logic      [LW-1:0] pos_torque_limit,       // Positive limit
    output logic      [LW-1:0] neg_torque_limit,       // Negative limit
    output logic      [SW-1:0] speed_cmd,              // Signed speed command
    output logic               speed_is_analog,        // Analog source chosen
    output logic               torque_dir_negative,    // Torque direction
    output logic      [LW-1:0] inertia_ratio,          // Active inertia ratio
    output logic               forced_alarm_error,     // Alarm raised
    output logic               irq                     // Interrupt, high
);
    initial if (LW < 2 || LW > 16 || SW < 2 || SW > 16 || TICK_CYC < 1)
        $error("servo_input_selection_logic parameters out of range");

    localparam int NIN = 9;
    localparam int TCW = $clog2(TICK_CYC + 1);

    // Synchronised pins, bit order fixed below
    logic [NIN-1:0] pins;
    logic [NIN-1:0] in_d;
    logic [NIN-1:0] in_q;
    assign pins = {inertia_switch_in, forced_alarm_in, torque_sign_in, speed_sign_in,
                   zero_clamp_in, speed_sel_bit2, speed_sel_bit1, speed_sel_bit0,
                   torque_limit_select_in};

    input_sync #(.W(NIN)) u_sync (
        .clk      (pclk),
        .rst_n    (presetn),
        .async_in (pins),
        .stable_d (in_d),
        .stable_q (in_q)
    );

    speed_rd_if #(.DW(SW)) spd ();
    speed_mem #(.DW(SW)) u_mem (
        .clk  (pclk),
        .port (spd)
    );

    // Software state
    logic [31:0]                  ctrl_q;
    servo_sel_pkg::limit_t        tl1_q;
    servo_sel_pkg::limit_t        tl2_q;
    servo_sel_pkg::limit_t        slope1_q;
    servo_sel_pkg::limit_t        slope2_q;
    servo_sel_pkg::limit_t        iner1_q;
    servo_sel_pkg::limit_t        iner2_q;
    logic [1:0]                   int_stat_q;
    logic [1:0]                   int_mask_q;
    logic [2:0]                   tl_mode;
    logic [1:0]                   src_mode;
    assign tl_mode  = ctrl_q[`CTRL_TLSEL_LSB +: 3];
    assign src_mode = ctrl_q[`CTRL_SRC_LSB +: 2];

    // Bus decode; every transfer has exactly one wait state
    logic       acc;
    logic       wr_done;
    logic [7:0] a;
    logic       in_table;
    logic       mapped;
    assign acc      = psel && penable && pready;
    assign wr_done  = acc && pwrite;
    assign a        = {paddr[7:2], 2'b00};
    assign in_table = (a >= `OFS_SPEED_BASE) && (a <= `OFS_SPEED_LAST);
    assign mapped   = in_table || (a <= `OFS_INT_MASK);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    // Register writes land only at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= `CTRL_RESET;
            tl1_q      <= `TL_RESET;
            tl2_q      <= `TL_RESET;
            slope1_q   <= 16'h0000;
            slope2_q   <= 16'h0000;
            iner1_q    <= `INER_RESET;
            iner2_q    <= `INER_RESET;
            int_mask_q <= 2'h0;
        end else if (wr_done) begin
            case (a)
                `OFS_CTRL:        ctrl_q     <= pwdata & 32'h0000_1133;
                `OFS_TL_FIRST:    tl1_q      <= pwdata[15:0];
                `OFS_TL_SECOND:   tl2_q      <= pwdata[15:0];
                `OFS_SLOPE_FIRST: slope1_q   <= pwdata[15:0];
                `OFS_SLOPE_SECND: slope2_q   <= pwdata[15:0];
                `OFS_INER_FIRST:  iner1_q    <= pwdata[15:0];
                `OFS_INER_SECND:  iner2_q    <= pwdata[15:0];
                `OFS_INT_MASK:    int_mask_q <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // Table port: setup-phase address, data next cycle
    assign spd.bus_addr = paddr[4:2];
    assign spd.wr_en    = wr_done && in_table;
    assign spd.wr_data  = pwdata[SW-1:0];

    // Index from next filtered inputs so data arrive with them
    logic [2:0] idx_d;
    logic       analog_d;
    always_comb begin
        idx_d    = {1'b0, in_d[2], in_d[1]};
        analog_d = 1'b0;
        if (src_mode == `SRC_ANALOG && in_d[1] && in_d[2]) begin
            analog_d = 1'b1;
        end
        if (src_mode == `SRC_EIGHT) begin
            idx_d = {in_d[3], in_d[2], in_d[1]};
        end
    end
    assign spd.sel_addr = idx_d;

    // Analog choice delayed to match the table read
    logic analog_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_q <= 1'b0;
        end else begin
            analog_q <= analog_d;
        end
    end

    // Speed command: source, zero clamp, then sign
    logic [SW-1:0] spd_raw;
    assign spd_raw = analog_q ? analog_speed_in : spd.sel_data;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_cmd       <= '0;
            speed_is_analog <= 1'b0;
        end else begin
            speed_is_analog <= analog_q;
            if (ctrl_q[`CTRL_ZCLAMP_BIT] && in_q[4]) begin
                speed_cmd <= '0;
            end else if (!ctrl_q[`CTRL_TORQUE_BIT] && in_q[5]) begin
                speed_cmd <= SW'(-spd_raw);
            end else begin
                speed_cmd <= spd_raw;
            end
        end
    end

    // Torque direction and inertia ratio
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            torque_dir_negative <= 1'b0;
            inertia_ratio       <= '0;
        end else begin
            torque_dir_negative <= ctrl_q[`CTRL_TORQUE_BIT] && in_d[6];
            inertia_ratio       <= in_d[8] ? LW'(iner2_q) : LW'(iner1_q);
        end
    end

    // Free-running step timer; step timing ignores the switch edge
    logic [TCW-1:0] tick_cnt_q;
    logic           tick;
    assign tick = (tick_cnt_q == TCW'(TICK_CYC - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + TCW'(1);
        end
    end

    // Torque limit ramp engine
    servo_sel_pkg::ramp_state_t state_q;
    servo_sel_pkg::limit_t      active_q;
    servo_sel_pkg::limit_t      target_q;
    servo_sel_pkg::limit_t      step_q;
    logic                       sel_q;
    logic                       ramp_done;
    logic                       sel_chg;
    logic                       new_sel;
    servo_sel_pkg::limit_t      new_tgt;
    servo_sel_pkg::limit_t      new_step;
    logic [16:0]                up_sum;
    logic [16:0]                dn_dif;
    assign new_sel  = in_d[0];
    assign sel_chg  = (new_sel != sel_q);
    assign new_tgt  = new_sel ? tl2_q : tl1_q;
    assign new_step = new_sel ? slope1_q : slope2_q;
    assign up_sum   = {1'b0, active_q} + {1'b0, step_q};
    assign dn_dif   = {1'b0, active_q} - {1'b0, step_q};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= servo_sel_pkg::RAMP_HOLD;
            active_q  <= `TL_RESET;
            target_q  <= `TL_RESET;
            step_q    <= 16'h0000;
            sel_q     <= 1'b0;
            ramp_done <= 1'b0;
        end else begin
            sel_q     <= new_sel;
            ramp_done <= 1'b0;
            if (tl_mode != `TLSEL_RAMPED) begin
                // Other modes follow the values directly
                state_q  <= servo_sel_pkg::RAMP_HOLD;
                active_q <= new_tgt;
                target_q <= new_tgt;
            end else if (sel_chg) begin
                target_q <= new_tgt;
                step_q   <= new_step;
                if (slope1_q == 16'h0000 && slope2_q == 16'h0000 || new_step == 16'h0000) begin
                    active_q <= new_tgt;
                    state_q  <= servo_sel_pkg::RAMP_HOLD;
                end else begin
                    state_q <= servo_sel_pkg::RAMP_SLEW;
                end
            end else if (wr_done && ((a == `OFS_TL_FIRST && !sel_q) ||
                                     (a == `OFS_TL_SECOND && sel_q))) begin
                active_q <= pwdata[15:0];
                target_q <= pwdata[15:0];
                state_q  <= servo_sel_pkg::RAMP_HOLD;
            end else begin
                unique case (state_q)
                    servo_sel_pkg::RAMP_HOLD: ;
                    servo_sel_pkg::RAMP_SLEW: begin
                        if (tick) begin
                            // Direction from the sign of the gap; clamp at target
                            if (active_q < target_q) begin
                                if (up_sum >= {1'b0, target_q}) begin
                                    active_q  <= target_q;
                                    state_q   <= servo_sel_pkg::RAMP_HOLD;
                                    ramp_done <= 1'b1;
                                end else begin
                                    active_q <= up_sum[15:0];
                                end
                            end else if (dn_dif[16] || dn_dif[15:0] <= target_q) begin
                                active_q  <= target_q;
                                state_q   <= servo_sel_pkg::RAMP_HOLD;
                                ramp_done <= 1'b1;
                            end else begin
                                active_q <= dn_dif[15:0];
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Limit outputs per selection mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_torque_limit <= '0;
            neg_torque_limit <= '0;
        end else if (tl_mode == `TLSEL_RAMPED) begin
            pos_torque_limit <= LW'(active_q);
            neg_torque_limit <= LW'(active_q);
        end else if (tl_mode == `TLSEL_SPLIT) begin
            pos_torque_limit <= LW'(tl1_q);
            neg_torque_limit <= LW'(tl2_q);
        end else begin
            pos_torque_limit <= LW'(tl1_q);
            neg_torque_limit <= LW'(tl1_q);
        end
    end

    // Sticky events; a new event beats a write-one-to-clear in the same cycle
    logic       alarm_prev_q;
    logic [1:0] ev;
    logic [1:0] clr;
    logic [1:0] stat_d;
    assign ev[`INT_ALARM_BIT] = in_q[7] && !alarm_prev_q;
    assign ev[`INT_RAMP_BIT]  = ramp_done;
    assign clr    = (wr_done && a == `OFS_INT_STATUS) ? pwdata[1:0] : 2'h0;
    assign stat_d = (int_stat_q & ~clr) | ev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_prev_q       <= 1'b0;
            int_stat_q         <= 2'h0;
            irq                <= 1'b0;
            forced_alarm_error <= 1'b0;
        end else begin
            alarm_prev_q       <= in_q[7];
            int_stat_q         <= stat_d;
            irq                <= |(stat_d & int_mask_q);
            forced_alarm_error <= stat_d[`INT_ALARM_BIT];
        end
    end

    // Read mux, sampled in the first access cycle so table data are ready
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (in_table) begin
            rd_mux = 32'(spd.bus_data);
        end else begin
            case (a)
                `OFS_CTRL:        rd_mux = ctrl_q;
                `OFS_TL_FIRST:    rd_mux = 32'(tl1_q);
                `OFS_TL_SECOND:   rd_mux = 32'(tl2_q);
                `OFS_SLOPE_FIRST: rd_mux = 32'(slope1_q);
                `OFS_SLOPE_SECND: rd_mux = 32'(slope2_q);
                `OFS_INER_FIRST:  rd_mux = 32'(iner1_q);
                `OFS_INER_SECND:  rd_mux = 32'(iner2_q);
                `OFS_STATE:       rd_mux = {5'h00, state_q, in_q, active_q};
                `OFS_SPEED_OUT:   rd_mux = {15'h0000, speed_is_analog, 16'(speed_cmd)};
                `OFS_INT_STATUS:  rd_mux = {30'h0, int_stat_q};
                `OFS_INT_MASK:    rd_mux = {30'h0, int_mask_q};
                default:          rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= !mapped;
        end else begin
            pslverr <= 1'b0;
        end
    end
endmodule // servo_input_selection_logic

// file: bench/servo_sel_props.sv
// Port-level assertions for the input selection logic
`timescale 1ns/1ps
module servo_sel_props #(
    parameter int LW = 16, // Limit width
    parameter int SW = 16  // Speed width
) (
    input wire logic          pclk,               // Clock
    input wire logic          presetn,            // Reset, low
    input wire logic          psel,               // APB select
    input wire logic          penable,            // APB enable
    input wire logic          pwrite,             // APB direction
    input wire logic [7:0]    paddr,              // APB address
    input wire logic          pready,             // APB ready
    input wire logic          pslverr,            // APB error
    input wire logic          speed_sel_bit0,     // Selector 1
    input wire logic          speed_sel_bit1,     // Selector 2
    input wire logic          speed_sel_bit2,     // Selector 3
    input wire logic          zero_clamp_in,      // Zero clamp
    input wire logic          speed_sign_in,      // Speed sign
    input wire logic          torque_sign_in,     // Torque sign
    input wire logic          forced_alarm_in,    // Alarm pin
    input wire logic          inertia_switch_in,  // Inertia pin
    input wire logic [SW-1:0] analog_speed_in,    // Analog word
    input wire logic [SW-1:0] speed_cmd,          // Speed out
    input wire logic          torque_dir_negative,// Direction out
    input wire logic [LW-1:0] inertia_ratio,      // Ratio out
    input wire logic          forced_alarm_error  // Alarm status
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus phases; quiet spell outlasting the pin filter
    sequence s_setup; psel && !penable; endsequence
    sequence s_wait; psel && penable && !pready; endsequence
    sequence s_quiet;
        (!psel && $stable({speed_sel_bit2, speed_sel_bit1, speed_sel_bit0, zero_clamp_in,
                           speed_sign_in, analog_speed_in}))[*8];
    endsequence
    a_one_wait_state: assert property (s_setup ##1 s_wait |=> pready)
        else $error("late ready");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("long ready");
    a_ready_cause: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("stray ready");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("stray error");
    a_alarm_sticky: assert property (forced_alarm_error && !(psel && penable && pready
        && pwrite && paddr == 8'h24) |=> forced_alarm_error) else $error("alarm lost");
    a_alarm_raise: assert property (!forced_alarm_in ##1 forced_alarm_in [*8]
        |-> ##[0:2] forced_alarm_error) else $error("no alarm");
    a_speed_hold: assert property (s_quiet |=> $stable(speed_cmd))
        else $error("speed moved");
    a_ratio_hold: assert property ((!psel && $stable(inertia_switch_in))[*8]
        |=> $stable(inertia_ratio)) else $error("ratio moved");
    a_dir_hold: assert property ((!psel && $stable(torque_sign_in))[*8]
        |=> $stable(torque_dir_negative)) else $error("dir moved");
endmodule // servo_sel_props

// file: bench/servo_host.sv
// Host controller model driving the discrete selector pins
`timescale 1ns/1ps
module servo_host (
    input  wire logic        pclk,  // Clock
    output logic      [8:0]  pins,  // Discrete levels
    output logic      [15:0] analog // Analog speed word
);
    // Idle host: all lines inactive
    initial {pins, analog} = '0;
    // Change just after an edge and hold
    task automatic put(input logic [8:0] v, input logic [15:0] a);
        @(posedge pclk);
        {pins, analog} <= {v, a};
    endtask
endmodule // servo_host

// file: bench/servo_input_selection_logic_tb.sv
// Self-checking bench for the input selection logic
`timescale 1ns/1ps
module servo_input_selection_logic_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
    logic        alog, tdir, alarm, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [8:0]  pins;
    logic [15:0] an, pos_l, neg_l, spd, ratio, lv, r1, r2;
    logic [15:0] tbl [8];
    int          fail_count, checks_done;
    servo_host host (.pclk(pclk), .pins(pins), .analog(an));
    servo_input_selection_logic #(.TICK_CYC(2)) uut (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .torque_limit_select_in(pins[0]), .speed_sel_bit0(pins[1]), .speed_sel_bit1(pins[2]),
        .speed_sel_bit2(pins[3]), .zero_clamp_in(pins[4]), .speed_sign_in(pins[5]),
        .torque_sign_in(pins[6]), .forced_alarm_in(pins[7]), .inertia_switch_in(pins[8]),
        .analog_speed_in(an), .pos_torque_limit(pos_l), .neg_torque_limit(neg_l),
        .speed_cmd(spd), .speed_is_analog(alog), .torque_dir_negative(tdir),
        .inertia_ratio(ratio), .forced_alarm_error(alarm), .irq);
    // Clock at 25 MHz
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer, held until ready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rdv, perr} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    // Pin filter plus output register fit well inside this
    task automatic settle();
        repeat (10) @(posedge pclk);
    endtask
    task automatic wait_lim(output logic [15:0] v);
        logic [15:0] o;
        o = pos_l;
        do @(negedge pclk); while (pos_l === o);
        v = pos_l;
    endtask
    function automatic logic [15:0] exp_spd(input int src, input logic [2:0] s);
        if (src == 2 && s[1:0] == 2'h3) return an;
        return tbl[{src == 3 && s[2], s[1:0]}];
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard; tests need a little over a thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        results();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        fail_count = 0;
        checks_done = 0;
        void'($urandom(75));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl", rdv, 32'h11);
        apb(1'b0, 8'h14, 32'h0);
        chk("ratio1", rdv, 32'h64);
        chk("pos", pos_l, 16'h0bb8);
        apb(1'b0, 8'h30, 32'h0);
        chk("unmapped", {rdv[30:0], perr}, 32'h1);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            tbl[i] = 16'($urandom());
            apb(1'b1, 8'h40 + 8'(4 * i), {16'h0, tbl[i]});
        end
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, 8'h00, 32'(m * 16 + 1));
            for (int s = 0; s < 8; s++) begin
                host.put(9'(s * 2), 16'($urandom()));
                settle();
                chk("speed", spd, exp_spd(m, 3'(s)));
                chk("analog", alog, m == 2 && s % 4 == 3);
            end
        end
        apb(1'b1, 8'h00, 32'h131);
        host.put(9'h014, an);
        settle();
        chk("clamp", spd, 16'h0);
        apb(1'b1, 8'h00, 32'h31);
        settle();
        chk("unclamped", spd, tbl[2]);
        host.put(9'h024, an);
        settle();
        chk("sign", spd, 16'(-tbl[2]));
        apb(1'b1, 8'h00, 32'h1011);
        host.put(9'h040, an);
        settle();
        chk("tdir on", tdir, 1'b1);
        host.put(9'h000, an);
        settle();
        chk("tdir off", tdir, 1'b0);
        r1 = 16'($urandom());
        r2 = 16'($urandom());
        apb(1'b1, 8'h14, {16'h0, r1});
        apb(1'b1, 8'h18, {16'h0, r2});
        settle();
        chk("ratio off", ratio, r1);
        host.put(9'h100, an);
        settle();
        chk("ratio on", ratio, r2);
        $display("selection tests done");
        apb(1'b1, 8'h24, 32'h3);
        apb(1'b1, 8'h28, 32'h1);
        host.put(9'h080, an);
        settle();
        chk("alarm", {alarm, irq}, 2'b11);
        host.put(9'h000, an);
        apb(1'b1, 8'h24, 32'h1);
        settle();
        chk("alarm clr", {alarm, irq}, 2'b00);
        $display("alarm test done");
        apb(1'b1, 8'h04, 32'h100);
        apb(1'b1, 8'h08, 32'h140);
        apb(1'b1, 8'h0c, 32'h1);
        apb(1'b1, 8'h10, 32'h2);
        apb(1'b1, 8'h00, 32'h13);
        host.put(9'h001, an);
        wait_lim(lv);
        chk("ramp up", lv, 16'h101);
        repeat (200) @(posedge pclk);
        chk("up end", pos_l, 16'h140);
        host.put(9'h000, an);
        wait_lim(lv);
        chk("ramp down", lv, 16'h13e);
        repeat (200) @(posedge pclk);
        chk("down end", pos_l, 16'h100);
        host.put(9'h001, an);
        repeat (200) @(posedge pclk);
        apb(1'b1, 8'h08, 32'h180);
        settle();
        chk("rewrite", pos_l, 16'h180);
        apb(1'b1, 8'h0c, 32'h0);
        apb(1'b1, 8'h10, 32'h0);
        host.put(9'h000, an);
        wait_lim(lv);
        chk("no slope", lv, 16'h100);
        apb(1'b1, 8'h00, 32'h11);
        host.put(9'h001, an);
        settle();
        chk("mode one", pos_l, 16'h100);
        apb(1'b1, 8'h00, 32'h12);
        settle();
        chk("mode two", {pos_l, neg_l}, 32'h0100_0180);
        $display("torque limit test done");
        results();
    end
endmodule // servo_input_selection_logic_tb
bind servo_input_selection_logic servo_sel_props #(.LW(LW), .SW(SW)) u_props (.*);
